//--- ftx_pkg.sv
`default_nettype none
package ftx_pkg;
	// register byte addresses
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_CLKDIV = 5'h04;
	localparam logic [4:0] ADDR_DEV = 5'h08;
	localparam logic [4:0] ADDR_SYNC = 5'h0c;
	localparam logic [4:0] ADDR_STATUS = 5'h10;
	// control word field positions
	localparam int CTRL_MOD_LSB = 0;
	localparam int CTRL_ROLL_BIT = 3;
	localparam int CTRL_INV_LSB = 4;
	localparam int CTRL_PAT_LSB = 8;
	localparam int CTRL_UART_BIT = 12;
	// status word field positions
	localparam int STAT_LVL_LSB = 0;
	localparam int STAT_FILT_LSB = 4;
	localparam int STAT_HALF_BIT = 6;
	localparam int STAT_UART_BIT = 7;
	localparam int STAT_RUN_BIT = 8;
	// reset values
	localparam logic [15:0] CLKDIV_RST = 16'h0001;
	localparam logic [8:0] DEV_RST = 9'h001;
	localparam logic [23:0] SYNC_RST = 24'h000000;
	localparam logic [8:0] PN9_SEED = 9'h1ff;
	// modulation select codes
	localparam logic [2:0] MOD_2FSK = 3'h0;
	localparam logic [2:0] MOD_GFSK = 3'h1;
	localparam logic [2:0] MOD_3FSK = 3'h2;
	localparam logic [2:0] MOD_4FSK = 3'h3;
	localparam logic [2:0] MOD_OS2FSK = 3'h4;
	localparam logic [2:0] MOD_RC2FSK = 3'h5;
	localparam logic [2:0] MOD_RC3FSK = 3'h6;
	localparam logic [2:0] MOD_RC4FSK = 3'h7;
	// test pattern codes
	localparam logic [2:0] PAT_NORMAL = 3'h0;
	localparam logic [2:0] PAT_CARRIER = 3'h1;
	localparam logic [2:0] PAT_PLUS = 3'h2;
	localparam logic [2:0] PAT_MINUS = 3'h3;
	localparam logic [2:0] PAT_ALT = 3'h4;
	localparam logic [2:0] PAT_PN9 = 3'h5;
	localparam logic [2:0] PAT_SYNC = 3'h6;
	// timing: 32 sub-ticks per bit, clock rises entering sub-tick 16
	localparam logic [4:0] SUB_RISE_LAST = 5'h0f;
	localparam logic [4:0] SUB_FALL_LAST = 5'h1f;
	localparam logic [4:0] SUB_HIGH_FIRST = 5'h10;
	// latency taps in symbol events
	localparam logic [5:0] LAT_NONE = 6'h01;
	localparam logic [5:0] LAT_GAUSS = 6'h04;
	localparam logic [5:0] LAT_RC05 = 6'h05;
	localparam logic [5:0] LAT_RC07 = 6'h04;
	localparam logic [5:0] LAT_OS = 6'h20;
	// symbol levels
	localparam logic signed [2:0] LVL_M3 = -3'sd3;
	localparam logic signed [2:0] LVL_M1 = -3'sd1;
	localparam logic signed [2:0] LVL_0 = 3'sd0;
	localparam logic signed [2:0] LVL_P1 = 3'sd1;
	localparam logic signed [2:0] LVL_P3 = 3'sd3;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {FILT_NONE, FILT_GAUSS, FILT_RC} ftx_filter_type;

	typedef struct packed {
		logic uart_sel;
		logic [2:0] pattern;
		logic [1:0] clk_inv;
		logic rolloff;
		logic [2:0] mod;
	} ftx_ctrl_type;

	typedef struct packed {
		logic signed [2:0] level;
		logic signed [11:0] freq_word;
	} ftx_sym_type;
endpackage
`default_nettype wire

//--- ftx_symbol_mapper.sv
// Behaviour
// - 3-level mode precodes input bits, then applies the convolutional encoder.
// - 3-level output outside the tone patterns never has three equal nonzero symbols in a row; dc-free.
// - 3-level mode emits one symbol per input bit.
// - modulation code 010 selects unfiltered 3-level FSK.
// - 4-level mode pairs bits into one of four symbols, half rate.
// - 4-level pair-to-level map is gray coded.
// - inner levels use programmed deviation, outer levels three times it.
// - clock starts after divider write; first pulse takes first symbol MSB.
// - oversampled binary mode: no data clock, sample input at 32x rate.
// - only oversampled binary mode accepts data from the UART-style interface.
// - code 001 selects Gaussian filtering, binary only, BT 0.5.
// - raised-cosine roll-off 0.5 by default, 0.7 when select bit is one.
// - modulation select codes decode to the eight documented schemes.
// - unfiltered: sampled bit or symbol reaches output one period later.
// - filtered latencies: Gaussian 4, cosine 0.5 gives 5, 0.7 gives 4.
// - inverted clock samples on falling edge, adding half a bit latency.
// - test pattern select chooses normal, carrier, tones, 1010, PN9 or sync.
// - test patterns run at the programmed data rate.
// - encoder is one minus two-sample delay, precoder its modulo-2 inverse.
// - 3-level zero gives carrier, plus or minus one gives one deviation.
// - 4-level pairs map to plus or minus three or one deviation.
// - all modes except oversampled binary output a bit-rate clock.
`timescale 1ns/100ps
`default_nettype none
module ftx_symbol_mapper #(
	parameter int DL_DEPTH = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial data link
	input wire logic transmit_bit_in,
	output logic tx_bit_clock_out,
	// modulator side
	output ftx_pkg::ftx_sym_type tx_symbol,
	output logic tx_symbol_strobe,
	output ftx_pkg::ftx_filter_type filter_kind,
	output logic rolloff_select_bit
);
	// ---------------- register bus ----------------
	logic aw_held_ff, nxt_aw_held;
	logic [4:0] awaddr_ff, nxt_awaddr;
	logic w_held_ff, nxt_w_held;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	ftx_pkg::ftx_ctrl_type ctrl_ff, nxt_ctrl;
	logic [15:0] clkdiv_ff, nxt_clkdiv;
	logic [8:0] dev_ff, nxt_dev;
	logic [23:0] sync_ff, nxt_sync;
	logic [31:0] ctrl_word, status_word, old_word, merged;
	logic [4:0] wr_addr;
	logic do_write, clk_start, sync_load;
	// datapath state read by the bus, except dl_ff
	logic signed [2:0] dl_ff [DL_DEPTH];
	logic half_ff;
	logic running_ff;
	logic uart_block;
	ftx_pkg::ftx_filter_type filt;

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always_comb
	begin
		ctrl_word = 32'h00000000;
		ctrl_word[ftx_pkg::CTRL_MOD_LSB +: 3] = ctrl_ff.mod;
		ctrl_word[ftx_pkg::CTRL_ROLL_BIT] = ctrl_ff.rolloff;
		ctrl_word[ftx_pkg::CTRL_INV_LSB +: 2] = ctrl_ff.clk_inv;
		ctrl_word[ftx_pkg::CTRL_PAT_LSB +: 3] = ctrl_ff.pattern;
		ctrl_word[ftx_pkg::CTRL_UART_BIT] = ctrl_ff.uart_sel;
		status_word = 32'h00000000;
		status_word[ftx_pkg::STAT_LVL_LSB +: 3] = tx_symbol.level;
		status_word[ftx_pkg::STAT_FILT_LSB +: 2] = filt;
		status_word[ftx_pkg::STAT_HALF_BIT] = half_ff;
		status_word[ftx_pkg::STAT_UART_BIT] = uart_block;
		status_word[ftx_pkg::STAT_RUN_BIT] = running_ff;
	end

	always_comb
	begin
		nxt_aw_held = aw_held_ff;
		nxt_awaddr = awaddr_ff;
		nxt_w_held = w_held_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		nxt_ctrl = ctrl_ff;
		nxt_clkdiv = clkdiv_ff;
		nxt_dev = dev_ff;
		nxt_sync = sync_ff;
		clk_start = 1'b0;
		sync_load = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			nxt_aw_held = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			nxt_w_held = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		wr_addr = nxt_awaddr;
		do_write = nxt_aw_held && nxt_w_held && !bvalid_ff;
		unique case (wr_addr)
			ftx_pkg::ADDR_CTRL: old_word = ctrl_word;
			ftx_pkg::ADDR_CLKDIV: old_word = {16'h0000, clkdiv_ff};
			ftx_pkg::ADDR_DEV: old_word = {23'h000000, dev_ff};
			ftx_pkg::ADDR_SYNC: old_word = {8'h00, sync_ff};
			default: old_word = 32'h00000000;
		endcase
		for (int i = 0; i < 4; i++)
			merged[i*8 +: 8] = nxt_wstrb[i] ? nxt_wdata[i*8 +: 8] : old_word[i*8 +: 8];
		if (do_write)
		begin
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = ftx_pkg::RESP_OKAY;
			unique case (wr_addr)
				ftx_pkg::ADDR_CTRL:
				begin
					nxt_ctrl.mod = merged[ftx_pkg::CTRL_MOD_LSB +: 3];
					nxt_ctrl.rolloff = merged[ftx_pkg::CTRL_ROLL_BIT];
					nxt_ctrl.clk_inv = merged[ftx_pkg::CTRL_INV_LSB +: 2];
					nxt_ctrl.pattern = merged[ftx_pkg::CTRL_PAT_LSB +: 3];
					nxt_ctrl.uart_sel = merged[ftx_pkg::CTRL_UART_BIT];
				end
				ftx_pkg::ADDR_CLKDIV:
				begin
					// a zero divider would stall the clock; treat it as one
					nxt_clkdiv = (merged[15:0] == 16'h0000) ? 16'h0001 : merged[15:0];
					clk_start = 1'b1;
				end
				ftx_pkg::ADDR_DEV: nxt_dev = merged[8:0];
				ftx_pkg::ADDR_SYNC:
				begin
					nxt_sync = merged[23:0];
					sync_load = 1'b1;
				end
				ftx_pkg::ADDR_STATUS: nxt_bresp = ftx_pkg::RESP_OKAY;
				default: nxt_bresp = ftx_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid_ff && s_axi_bready)
			nxt_bvalid = 1'b0;
		if (rvalid_ff && s_axi_rready)
			nxt_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp = ftx_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				ftx_pkg::ADDR_CTRL: nxt_rdata = ctrl_word;
				ftx_pkg::ADDR_CLKDIV: nxt_rdata = {16'h0000, clkdiv_ff};
				ftx_pkg::ADDR_DEV: nxt_rdata = {23'h000000, dev_ff};
				ftx_pkg::ADDR_SYNC: nxt_rdata = {8'h00, sync_ff};
				ftx_pkg::ADDR_STATUS: nxt_rdata = status_word;
				default:
				begin
					nxt_rdata = 32'h00000000;
					nxt_rresp = ftx_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= 5'h00;
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= ftx_pkg::RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= ftx_pkg::RESP_OKAY;
			ctrl_ff <= '0;
			clkdiv_ff <= ftx_pkg::CLKDIV_RST;
			dev_ff <= ftx_pkg::DEV_RST;
			sync_ff <= ftx_pkg::SYNC_RST;
		end
		else
		begin
			aw_held_ff <= nxt_aw_held;
			awaddr_ff <= nxt_awaddr;
			w_held_ff <= nxt_w_held;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			ctrl_ff <= nxt_ctrl;
			clkdiv_ff <= nxt_clkdiv;
			dev_ff <= nxt_dev;
			sync_ff <= nxt_sync;
		end
	end

	// ---------------- bit timing ----------------
	logic [15:0] div_cnt_ff, nxt_div_cnt;
	logic [4:0] sub_cnt_ff, nxt_sub_cnt;
	logic nxt_running, clk_out_ff, nxt_clk_out;
	logic sub_tick, bit_tick, samp, samp_os, os_mode;

	assign os_mode = ctrl_ff.mod == ftx_pkg::MOD_OS2FSK;
	assign sub_tick = running_ff && (div_cnt_ff >= clkdiv_ff - 16'h0001);
	assign bit_tick = sub_tick && sub_cnt_ff == ftx_pkg::SUB_RISE_LAST;
	// rising edge by default, falling edge when inverted
	assign samp = sub_tick && !os_mode &&
		sub_cnt_ff == ((ctrl_ff.clk_inv != 2'h0) ? ftx_pkg::SUB_FALL_LAST : ftx_pkg::SUB_RISE_LAST);
	assign samp_os = sub_tick && os_mode;
	assign tx_bit_clock_out = clk_out_ff;

	always_comb
	begin
		nxt_running = running_ff;
		nxt_div_cnt = sub_tick ? 16'h0000 : div_cnt_ff + 16'h0001;
		nxt_sub_cnt = sub_tick ? sub_cnt_ff + 5'h01 : sub_cnt_ff;
		if (clk_start)
		begin
			nxt_running = 1'b1;
			nxt_div_cnt = 16'h0000;
			nxt_sub_cnt = 5'h00;
		end
		if (!nxt_running)
			nxt_div_cnt = 16'h0000;
		// clock starts low so the first rising edge is the first pulse
		nxt_clk_out = nxt_running && !os_mode && nxt_sub_cnt >= ftx_pkg::SUB_HIGH_FIRST;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			running_ff <= 1'b0;
			div_cnt_ff <= 16'h0000;
			sub_cnt_ff <= 5'h00;
			clk_out_ff <= 1'b0;
		end
		else
		begin
			running_ff <= nxt_running;
			div_cnt_ff <= nxt_div_cnt;
			sub_cnt_ff <= nxt_sub_cnt;
			clk_out_ff <= nxt_clk_out;
		end
	end

	// ---------------- test patterns ----------------
	logic alt_ff, nxt_alt;
	logic [8:0] lfsr_ff, nxt_lfsr;
	logic [23:0] sync_sh_ff, nxt_sync_sh;
	logic pat_bit;

	always_comb
	begin
		nxt_alt = alt_ff;
		nxt_lfsr = lfsr_ff;
		nxt_sync_sh = sync_load ? nxt_sync : sync_sh_ff;
		if (bit_tick)
		begin
			nxt_alt = !alt_ff;
			nxt_lfsr = {lfsr_ff[7:0], lfsr_ff[8] ^ lfsr_ff[4]};
			if (!sync_load)
				nxt_sync_sh = {sync_sh_ff[22:0], sync_sh_ff[23]};
		end
		unique case (ctrl_ff.pattern)
			ftx_pkg::PAT_ALT: pat_bit = alt_ff;
			ftx_pkg::PAT_PN9: pat_bit = lfsr_ff[8];
			ftx_pkg::PAT_SYNC: pat_bit = sync_sh_ff[23];
			default: pat_bit = transmit_bit_in;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			alt_ff <= 1'b1;
			lfsr_ff <= ftx_pkg::PN9_SEED;
			sync_sh_ff <= ftx_pkg::SYNC_RST;
		end
		else
		begin
			alt_ff <= nxt_alt;
			lfsr_ff <= nxt_lfsr;
			sync_sh_ff <= nxt_sync_sh;
		end
	end

	// ---------------- symbol mapping and latency ----------------
	logic p1_ff, p2_ff, nxt_p1, nxt_p2, nxt_half, msb_ff, nxt_msb;
	logic signed [2:0] nxt_dl [DL_DEPTH];
	ftx_pkg::ftx_sym_type out_ff, nxt_out;
	logic strobe_ff, nxt_strobe;
	logic is3, is4, d, p, ev, forced;
	logic signed [2:0] lvl, dlv;
	logic [5:0] tap;

	assign is3 = ctrl_ff.mod == ftx_pkg::MOD_3FSK || ctrl_ff.mod == ftx_pkg::MOD_RC3FSK;
	assign is4 = ctrl_ff.mod == ftx_pkg::MOD_4FSK || ctrl_ff.mod == ftx_pkg::MOD_RC4FSK;
	assign uart_block = ctrl_ff.uart_sel && !os_mode;
	assign forced = ctrl_ff.pattern == ftx_pkg::PAT_CARRIER || ctrl_ff.pattern == ftx_pkg::PAT_PLUS ||
		ctrl_ff.pattern == ftx_pkg::PAT_MINUS;
	assign tx_symbol = out_ff;
	assign tx_symbol_strobe = strobe_ff;
	assign filter_kind = filt;
	assign rolloff_select_bit = ctrl_ff.rolloff;

	always_comb
	begin
		unique case (ctrl_ff.mod)
			ftx_pkg::MOD_GFSK: filt = ftx_pkg::FILT_GAUSS;
			ftx_pkg::MOD_RC2FSK, ftx_pkg::MOD_RC3FSK, ftx_pkg::MOD_RC4FSK: filt = ftx_pkg::FILT_RC;
			default: filt = ftx_pkg::FILT_NONE;
		endcase
		unique case (filt)
			ftx_pkg::FILT_GAUSS: tap = ftx_pkg::LAT_GAUSS;
			ftx_pkg::FILT_RC: tap = ctrl_ff.rolloff ? ftx_pkg::LAT_RC07 : ftx_pkg::LAT_RC05;
			default: tap = os_mode ? ftx_pkg::LAT_OS : ftx_pkg::LAT_NONE;
		endcase
	end

	always_comb
	begin
		nxt_p1 = p1_ff;
		nxt_p2 = p2_ff;
		nxt_half = clk_start ? 1'b0 : half_ff;
		nxt_msb = msb_ff;
		nxt_out = out_ff;
		nxt_strobe = 1'b0;
		nxt_dl = dl_ff;
		ev = 1'b0;
		lvl = ftx_pkg::LVL_0;
		p = 1'b0;
		d = (ctrl_ff.pattern == ftx_pkg::PAT_NORMAL) ? (transmit_bit_in && !uart_block) : pat_bit;
		if (samp || samp_os)
		begin
			ev = 1'b1;
			if (is3)
			begin
				p = d ^ p2_ff;
				lvl = 3'($signed({2'b00, p}) - $signed({2'b00, p2_ff}));
				nxt_p2 = p1_ff;
				nxt_p1 = p;
			end
			else if (is4)
			begin
				ev = half_ff;
				nxt_half = !half_ff;
				nxt_msb = d;
				unique case ({msb_ff, d})
					2'b00: lvl = ftx_pkg::LVL_M3;
					2'b01: lvl = ftx_pkg::LVL_M1;
					2'b11: lvl = ftx_pkg::LVL_P1;
					2'b10: lvl = ftx_pkg::LVL_P3;
				endcase
			end
			else
				lvl = d ? ftx_pkg::LVL_P1 : ftx_pkg::LVL_M1;
			unique case (ctrl_ff.pattern)
				ftx_pkg::PAT_CARRIER: lvl = ftx_pkg::LVL_0;
				ftx_pkg::PAT_PLUS: lvl = ftx_pkg::LVL_P1;
				ftx_pkg::PAT_MINUS: lvl = ftx_pkg::LVL_M1;
				default: lvl = lvl;
			endcase
		end
		// a divider write restarts pairing even if a sample lands in the same cycle
		if (clk_start)
			nxt_half = 1'b0;
		dlv = dl_ff[5'(tap - 6'h01)];
		if (ev)
		begin
			nxt_dl[0] = lvl;
			for (int i = 1; i < DL_DEPTH; i++)
				nxt_dl[i] = dl_ff[i-1];
			nxt_strobe = 1'b1;
			nxt_out.level = dlv;
			// zero level is carrier, magnitude 3 gives three deviations
			nxt_out.freq_word = $signed({{9{dlv[2]}}, dlv}) * $signed({3'b000, dev_ff});
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			p1_ff <= 1'b0;
			p2_ff <= 1'b0;
			half_ff <= 1'b0;
			msb_ff <= 1'b0;
			out_ff <= '0;
			strobe_ff <= 1'b0;
			for (int i = 0; i < DL_DEPTH; i++)
				dl_ff[i] <= ftx_pkg::LVL_0;
		end
		else
		begin
			p1_ff <= nxt_p1;
			p2_ff <= nxt_p2;
			half_ff <= nxt_half;
			msb_ff <= nxt_msb;
			out_ff <= nxt_out;
			strobe_ff <= nxt_strobe;
			dl_ff <= nxt_dl;
		end
	end

	// ---------------- checks ----------------
	logic [1:0] run3_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !is3 || forced)
			run3_ff <= 2'h0;
		else if (ev && run3_ff != 2'h3)
			run3_ff <= run3_ff + 2'h1;
	end

	AST_3LVL_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
		(is3 && !forced && run3_ff == 2'h3 && ev) |=> !(dl_ff[0] == dl_ff[1] && dl_ff[1] == dl_ff[2] && dl_ff[0] != 3'sd0))
		else $error("three equal nonzero 3-level symbols in a row");
	AST_3LVL_RATE: assert property (@(posedge aclk) disable iff (!aresetn)
		(samp && is3) |=> (dl_ff[1] == $past(dl_ff[0]) && strobe_ff))
		else $error("3-level sample did not yield one symbol");
	AST_4LVL_PAIR: assert property (@(posedge aclk) disable iff (!aresetn)
		(samp && is4 && !half_ff && !clk_start) |=> (!strobe_ff && half_ff))
		else $error("4-level symbol emitted on first bit of pair");
	AST_4LVL_GRAY: assert property (@(posedge aclk) disable iff (!aresetn)
		(samp && is4 && half_ff && !forced && msb_ff && !d) |=> dl_ff[0] == 3'sd3)
		else $error("bit pair 10 not mapped to outer plus level");
	AST_OUTER_DEV: assert property (@(posedge aclk) disable iff (!aresetn)
		(ev && dlv == -3'sd3) |=> tx_symbol.freq_word == -$signed({3'b000, $past(dev_ff)}) * 12'sd3)
		else $error("outer level is not three times deviation");
	AST_OS_NOCLK: assert property (@(posedge aclk) disable iff (!aresetn)
		(os_mode && $past(os_mode)) |-> !tx_bit_clock_out)
		else $error("bit clock running in oversampled mode");
	AST_CLK_START: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_start |=> (running_ff && sub_cnt_ff == 5'h00 && !tx_bit_clock_out))
		else $error("clock did not restart after divider write");
	AST_LAT_NONE: assert property (@(posedge aclk) disable iff (!aresetn)
		(samp && ctrl_ff.mod == ftx_pkg::MOD_2FSK) |=> tx_symbol.level == $past(dl_ff[0]))
		else $error("unfiltered latency is not one period");
	AST_LAT_GAUSS: assert property (@(posedge aclk) disable iff (!aresetn)
		(samp && ctrl_ff.mod == ftx_pkg::MOD_GFSK) |=> tx_symbol.level == $past(dl_ff[3]))
		else $error("gaussian latency is not four bits");
	AST_INV_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
		(samp && ctrl_ff.clk_inv != 2'h0) |-> tx_bit_clock_out)
		else $error("inverted clock sample not at falling edge");
	AST_PN9_LIVE: assert property (@(posedge aclk) disable iff (!aresetn)
		lfsr_ff != 9'h000)
		else $error("pn9 register locked at zero");
	AST_UART_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
		(samp && uart_block && ctrl_ff.pattern == ftx_pkg::PAT_NORMAL && ctrl_ff.mod == ftx_pkg::MOD_2FSK)
		|=> dl_ff[0] == -3'sd1)
		else $error("uart data accepted outside oversampled mode");
endmodule
`default_nettype wire

//--- ftx_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side: serial data msb first, next bit after each clock rise
module ftx_host_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// serial link
	input wire logic tx_bit_clock_out,
	input wire logic [15:0] pattern,
	output logic transmit_bit_in
);
	logic clk_ff;
	int idx;
	always @(posedge aclk)
	begin
		clk_ff <= tx_bit_clock_out;
		if (!aresetn)
			idx <= 0;
		else if (tx_bit_clock_out && !clk_ff)
			idx <= idx + 1;
	end
	// zeros after the pattern keep the tail flowing
	assign transmit_bit_in = (idx < 16) ? pattern[15 - idx] : 1'b0;
endmodule
`default_nettype wire

//--- ftx_symbol_mapper_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ftx_symbol_mapper_tb;
	typedef struct {logic [2:0] m; logic r; logic [15:0] b; int ns; int lat; ftx_pkg::ftx_filter_type fk;} ftx_row_type;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [4:0] awaddr = 5'h00;
	logic [4:0] araddr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [15:0] pat = 16'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rollb, tbit, bclk, strobe, ta, tw, tr;
	logic [1:0] bresp, rresp, rrs;
	logic [31:0] rdata, rd;
	logic signed [2:0] ev;
	ftx_pkg::ftx_sym_type sym;
	ftx_pkg::ftx_filter_type fkind;
	logic signed [2:0] lv[64];
	logic signed [11:0] fw[64];
	int n_obs, cyc, t_first, t_prev, t_last, err_total, n_compared, i, k, d0;
	ftx_row_type rows[8];
	localparam logic signed [2:0] G4[4] = '{ftx_pkg::LVL_M3, ftx_pkg::LVL_M1, ftx_pkg::LVL_P3, ftx_pkg::LVL_P1};
	localparam logic [23:0] SYNC_WORD = 24'hc5a381;

	always #2.5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	// record up to 64 symbol updates away from the launching edge
	always @(negedge aclk)
	begin
		if (strobe && n_obs < 64)
		begin
			lv[n_obs] = sym.level;
			fw[n_obs] = sym.freq_word;
			if (n_obs == 0) t_first = cyc;
			t_prev = t_last;
			t_last = cyc;
			n_obs = n_obs + 1;
		end
	end

	ftx_symbol_mapper u_ftx_symbol_mapper (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .transmit_bit_in(tbit), .tx_bit_clock_out(bclk), .tx_symbol(sym),
		.tx_symbol_strobe(strobe), .filter_kind(fkind), .rolloff_select_bit(rollb));
	ftx_host_model u_ftx_host_model (.aclk(aclk), .aresetn(aresetn), .tx_bit_clock_out(bclk),
		.pattern(pat), .transmit_bit_in(tbit));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task hang;
		err_total++;
		conclude();
	endtask

	task axw(input logic [4:0] a, input logic [31:0] d);
		int j;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (j = 0; j < 50; j++)
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tr = bvalid;
			rrs = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tr) break;
		end
		bready <= 1'b0;
		if (j == 50) hang();
	endtask

	task axr(input logic [4:0] a);
		int j;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (j = 0; j < 50; j++)
		begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			rd = rdata;
			rrs = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		if (j == 50) hang();
	endtask

	// reset, program, start the bit clock and collect ns symbol updates
	task run(input logic [31:0] ctrl, input int ns);
		int j;
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axw(ftx_pkg::ADDR_CTRL, ctrl);
		axw(ftx_pkg::ADDR_DEV, 32'h5);
		axw(ftx_pkg::ADDR_SYNC, {8'h00, SYNC_WORD});
		n_obs = 0;
		d0 = cyc;
		axw(ftx_pkg::ADDR_CLKDIV, 32'h1);
		for (j = 0; j < 6000 && n_obs < ns; j++) @(posedge aclk);
		if (n_obs < ns) hang();
	endtask

	// expected level of symbol k for bits b sent msb first
	function automatic logic signed [2:0] lev(input logic [2:0] m, input logic [15:0] b, input int k);
		logic [17:0] p;
		p = 18'h0;
		for (int j = 0; j < 16; j++) p[j + 2] = b[15 - j] ^ p[j];
		if (m[1:0] == 2'b10) return 3'(int'(p[k + 2]) - int'(p[k]));
		if (m[1:0] == 2'b11) return G4[{b[15 - 2 * k], b[14 - 2 * k]}];
		return b[15 - k] ? ftx_pkg::LVL_P1 : ftx_pkg::LVL_M1;
	endfunction

	initial
	begin
		rows = '{'{3'h0, 1'b0, 16'hb3a5, 16, 1, ftx_pkg::FILT_NONE}, '{3'h1, 1'b0, 16'h96c3, 12, 4, ftx_pkg::FILT_GAUSS},
			'{3'h5, 1'b0, 16'h5a3c, 12, 5, ftx_pkg::FILT_RC}, '{3'h5, 1'b1, 16'hc35a, 12, 4, ftx_pkg::FILT_RC},
			'{3'h2, 1'b0, 16'hb240, 10, 1, ftx_pkg::FILT_NONE}, '{3'h6, 1'b1, 16'he718, 14, 4, ftx_pkg::FILT_RC},
			'{3'h3, 1'b0, 16'h1e4b, 8, 1, ftx_pkg::FILT_NONE}, '{3'h7, 1'b0, 16'hb41e, 8, 5, ftx_pkg::FILT_RC}};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axr(ftx_pkg::ADDR_CTRL);
		check(rd, 32'h0);
		axr(ftx_pkg::ADDR_CLKDIV);
		check(rd, 32'h1);
		axr(ftx_pkg::ADDR_DEV);
		check(rd, 32'h1);
		axr(5'h14);
		check({30'h0, rrs}, {30'h0, ftx_pkg::RESP_SLVERR});
		axw(ftx_pkg::ADDR_SYNC, {8'h00, SYNC_WORD});
		check({30'h0, rrs}, {30'h0, ftx_pkg::RESP_OKAY});
		axw(5'h14, 32'h0);
		check({30'h0, rrs}, {30'h0, ftx_pkg::RESP_SLVERR});
		for (i = 0; i < 8; i++)
		begin
			pat <= rows[i].b;
			run({28'h0, rows[i].r, rows[i].m}, rows[i].ns + rows[i].lat);
			check(32'(fkind), 32'(rows[i].fk));
			check({31'h0, rollb}, {31'h0, rows[i].r});
			check(32'(t_last - t_prev), (rows[i].m[1:0] == 2'b11) ? 32'd64 : 32'd32);
			for (k = 0; k < rows[i].ns; k++)
			begin
				ev = lev(rows[i].m, rows[i].b, k);
				check(32'(lv[k + rows[i].lat]), 32'(ev));
				check(32'(fw[k + rows[i].lat]), 32'(int'(ev) * 5));
			end
		end
		pat <= 16'hffff;
		run(32'h4, 40);
		for (k = 0; k < 100 && bclk === 1'b0; k++) @(negedge aclk);
		check(32'(k), 32'd100);
		run(32'h1000, 4);
		check(32'(lv[3]), 32'(ftx_pkg::LVL_M1));
		for (i = 1; i < 4; i++)
		begin
			run({20'h0, 1'b0, 3'(i), 8'h0}, 6);
			check(32'(lv[5]), (i == 1) ? 32'h0 : ((i == 2) ? 32'h1 : 32'hffffffff));
			check(32'(t_last - t_prev), 32'd32);
		end
		run(32'h400, 8);
		check(32'(lv[6]), 32'(-lv[5]));
		check(32'(lv[5]), 32'h1);
		// all-ones seed gives nine ones, then the first feedback zero
		run(32'h500, 11);
		for (k = 0; k < 10; k++)
			check(32'(lv[k + 1]), (k < 9) ? 32'h1 : 32'hffffffff);
		run(32'h600, 26);
		for (k = 0; k < 25; k++)
			check(32'(lv[k + 1]), SYNC_WORD[23 - (k % 24)] ? 32'h1 : 32'hffffffff);
		run(32'h0, 2);
		k = t_first - d0;
		run(32'h10, 2);
		check(32'(t_first - d0 - k), 32'd16);
		conclude();
	end
endmodule
`default_nettype wire
